// [design/flash_protect_pkg.sv]
// Purpose: Shared opcodes, field positions and reset values for the flash protection block.
// Assumes: Serial link in mode 0, one data line each way, MSB first.
// Notes: Used by both ends, the assertions and the bench; the interface does not import it.
package flash_protect_pkg;
  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] write_enable_cmd = 8'h06;
  localparam logic [7:0] read_sector_lock_cmd = 8'hFA;
  localparam logic [7:0] read_sector_lock_wide_cmd = 8'hE0;
  localparam logic [7:0] write_sector_lock_cmd = 8'hFB;
  localparam logic [7:0] write_sector_lock_wide_cmd = 8'hE1;
  localparam logic [7:0] read_training_pattern_cmd = 8'h41;
  localparam logic [7:0] program_stored_pattern_cmd = 8'h43;
  localparam logic [7:0] write_working_pattern_cmd = 8'h44;
  localparam logic [7:0] read_correction_status_cmd = 8'hB3;
  localparam logic [7:0] write_correction_status_cmd = 8'hB5;
  localparam logic [7:0] clear_correction_status_cmd = 8'hB6;
  localparam logic [7:0] write_status_cmd = 8'h01;
  localparam logic [7:0] program_cmd = 8'h02;
  localparam logic [7:0] erase_cmd = 8'h20;
  // ****************************************
  // Values and fields
  // ****************************************
  localparam logic [7:0] lock_protected = 8'h00;
  localparam logic [7:0] lock_open = 8'hFF;
  localparam logic [7:0] stored_pattern_reset = 8'h00;
  localparam logic [7:0] correction_status_reset = 8'h00;
  localparam int correction_disable_bit = 0;
  localparam int correction_seen_bit = 1;
  localparam int tally_lsb = 2;
  localparam int tally_msb = 5;
  localparam logic [3:0] tally_max = 4'hF;
  localparam int partial_program_bit = 6;
  localparam int status_write_disable_bit = 7;
  localparam int quad_enable_bit = 6;
  localparam logic [7:0] status_reset = 8'h00;
  localparam int addr_short_bytes = 3;
  localparam int addr_wide_bytes = 4;
  // Link clock half period in system clocks.
  localparam logic [7:0] link_half_period = 8'h04;
  // ****************************************
  // Host register map (word byte addresses)
  // ****************************************
  localparam logic [3:0] reg_command = 4'h0;
  localparam logic [3:0] reg_address = 4'h4;
  localparam logic [3:0] reg_wdata = 4'h8;
  localparam logic [3:0] reg_rdata = 4'hC;
  localparam logic [3:0] reg_status = 4'h0;
  localparam int addr_bits = 4;
  localparam int sector_bits = 5;
endpackage

// [design/flash_link_if.sv]
// Purpose: Serial link between host controller and flash protection device.
// Assumes: Output enables are active low; a released line reads high.
// Notes: The device line level is resolved here from the device's data and output enable.
`timescale 1ns/1ns
interface flash_link_if;
  logic link_clock;
  logic select_n;
  logic host_data;
  logic dev_data;
  logic dev_data_oe_n;
  logic dev_line;
  assign dev_line = dev_data_oe_n ? 1'b1 : dev_data;
  modport host (output link_clock, output select_n, output host_data, input dev_line);
  modport device (input link_clock, input select_n, input host_data, output dev_data, output dev_data_oe_n);
endinterface

// [design/bit_sync.sv]
// Purpose: Two flip-flop synchroniser for link inputs.
// Assumes: One system clock.
// Notes: The first stage feeds only the second.
`timescale 1ns/1ns
module bit_sync #(
  parameter int width = 3,
  parameter logic [width-1:0] init = '1
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] meta_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meta_q <= init;
      sync_out <= init;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// [design/flash_protect_dev.sv]
// Purpose: Device end: sector locks, training pattern, correction status and write gating.
// Assumes: Link clock sampled by the system clock, at least four system clocks per half period.
// Notes: Commands end when select rises; writes take effect then.
// Overview of operation
// - Opcodes FA/E0 read addressed sector lock.
// - Opcodes FB/E1 write addressed sector lock.
// - Lock byte 00h blocks program and erase.
// - Lock byte FFh unprotects; resets to FFh.
// - Opcodes 41/43/44 read, program, write pattern.
// - Stored pattern is 8 bits, ships 00h.
// - Reset copies stored pattern into working; here reset also clears stored pattern to 00h first.
// - Working pattern writable any time, volatile.
// - Dummy cycles may carry working pattern.
// - Opcodes B3/B5/B6 read, write, clear status.
// - Bit 0 disables correction; resets 0.
// - Bit 1 read-only correction seen flag.
// - Bits 5:2 count corrections, saturate 15.
// - Partial program ignored, flagged in bit 6; here only while bit 0 is 0.
// - Guarded status bits locked when disable and pin low.
// - Writes need write enable latch set first; clear (B6) does not.
// - Region protected if either scheme protects.
// - Host should use only one scheme.
// - Persistent or dynamic bit zero protects region.
`timescale 1ns/1ns
module flash_protect_dev
  import flash_protect_pkg::*;
#(
  parameter int sectors = 32,
  parameter int dummy_bits = 8
) (
  input wire logic clock,
  input wire logic reset_n,
  flash_link_if.device link,
  input wire logic write_protect_n,
  input wire logic correction_event,
  input wire logic partial_program_attempt,
  input wire logic [sectors-1:0] persistent_sector_lock,
  input wire logic [sectors-1:0] region_guard_map,
  input wire logic address_wide,
  output logic [sectors-1:0] sector_protected,
  output logic program_accepted,
  output logic [7:0] status_q,
  output logic [7:0] training_pattern_working
);
  import flash_protect_pkg::*;
  // ****************************************
  // Link sampling
  // ****************************************
  logic [2:0] pins_s;
  logic sclk_q;
  bit_sync #(.width(3), .init(3'b010)) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in({link.link_clock, link.select_n, link.host_data}),
    .sync_out(pins_s)
  );
  // The write-protect pin is asynchronous as well.
  logic wp_n_s;
  bit_sync #(.width(1), .init(1'b1)) u_wp_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(write_protect_n),
    .sync_out(wp_n_s)
  );
  wire sclk_s = pins_s[2];
  wire sel_n_s = pins_s[1];
  wire mosi_s = pins_s[0];
  wire rise = sclk_s & ~sclk_q;
  wire fall = ~sclk_s & sclk_q;
  logic sel_q;
  wire frame_end = sel_n_s & sel_q;
  // ****************************************
  // Command shifter
  // ****************************************
  typedef enum {st_idle, st_op, st_addr, st_dummy, st_data} phase_t;
  phase_t phase_q;
  logic [7:0] shift_q, op_q, wdata_q, rdata_q, stored_q, ecc_q;
  logic [31:0] addr_q;
  logic [5:0] cnt_q;
  logic [sectors-1:0] dyn_lock_q;
  logic wel_q, got_data_q, out_q, oe_n_q;
  wire [7:0] shift_d = {shift_q[6:0], mosi_s};
  wire op_rd_lock = op_q == read_sector_lock_cmd || op_q == read_sector_lock_wide_cmd;
  wire op_wr_lock = op_q == write_sector_lock_cmd || op_q == write_sector_lock_wide_cmd;
  wire op_wide = op_q == read_sector_lock_wide_cmd || op_q == write_sector_lock_wide_cmd;
  wire [5:0] addr_len = 6'(8 * ((op_wide || address_wide) ? addr_wide_bytes : addr_short_bytes));
  wire [5:0] cnt_inc = cnt_q + 6'd1;
  wire [$clog2(sectors)-1:0] sec = addr_q[12 +: $clog2(sectors)];
  wire [7:0] new_op = shift_d;
  wire dummy_rd = new_op == read_training_pattern_cmd;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      sclk_q <= 1'b0;
      sel_q <= 1'b0;
    end else begin
      sclk_q <= sclk_s;
      sel_q <= ~sel_n_s;
    end
  end
  always_ff @(posedge clock) begin
    if (!reset_n || sel_n_s) begin
      phase_q <= st_op;
      cnt_q <= '0;
      got_data_q <= 1'b0;
      if (!reset_n) begin
        op_q <= '0;
        shift_q <= '0;
        addr_q <= '0;
        wdata_q <= '0;
      end
    end else if (rise) begin
      shift_q <= shift_d;
      cnt_q <= cnt_inc;
      case (phase_q)
        st_op: if (cnt_q == 6'd7) begin
          op_q <= new_op;
          cnt_q <= '0;
          phase_q <= (new_op == read_sector_lock_cmd || new_op == read_sector_lock_wide_cmd ||
                      new_op == write_sector_lock_cmd || new_op == write_sector_lock_wide_cmd ||
                      new_op == program_cmd || new_op == erase_cmd) ? st_addr :
                     dummy_rd ? st_dummy : st_data;
        end
        st_addr: begin
          addr_q <= {addr_q[30:0], mosi_s};
          if (cnt_inc == addr_len) begin
            cnt_q <= '0;
            phase_q <= st_data;
          end
        end
        st_dummy: if (cnt_inc == 6'(dummy_bits)) begin
          cnt_q <= '0;
          phase_q <= st_data;
        end
        st_data: if (cnt_q[2:0] == 3'd7) begin
          wdata_q <= shift_d;
          got_data_q <= 1'b1;
        end
        default: phase_q <= st_op;
      endcase
    end
  end
  // ****************************************
  // Read data select and output shifter
  // ****************************************
  wire [7:0] lock_byte = dyn_lock_q[sec] ? lock_open : lock_protected;
  always_comb begin
    case (op_q)
      read_sector_lock_cmd, read_sector_lock_wide_cmd: rdata_q = lock_byte;
      read_training_pattern_cmd: rdata_q = training_pattern_working;
      read_correction_status_cmd: rdata_q = ecc_q;
      default: rdata_q = 8'h00;
    endcase
  end
  // Drive on falling edges so the host samples a settled bit at the end of the next high phase.
  wire drive_pat = phase_q == st_dummy;
  wire drive_dat = phase_q == st_data && (op_rd_lock || op_q == read_training_pattern_cmd ||
                                          op_q == read_correction_status_cmd);
  wire [2:0] bit_i = 3'(7 - int'(cnt_q[2:0]));
  always_ff @(posedge clock) begin
    if (!reset_n || sel_n_s) begin
      out_q <= 1'b1;
      oe_n_q <= 1'b1;
    end else if (fall) begin
      oe_n_q <= ~(drive_pat | drive_dat);
      out_q <= drive_pat ? training_pattern_working[bit_i] : rdata_q[bit_i];
    end
  end
  assign link.dev_data = out_q;
  assign link.dev_data_oe_n = oe_n_q;
  // ****************************************
  // Register updates at frame end, on correction events and after reset
  // ****************************************
  wire writes = got_data_q && wel_q;
  wire guarded = status_q[status_write_disable_bit] && !wp_n_s;
  wire [sectors-1:0] both_prot = ~persistent_sector_lock | ~dyn_lock_q;
  wire [sectors-1:0] prot_d = both_prot | region_guard_map;
  wire target_prot = prot_d[sec];
  wire [3:0] tally = ecc_q[tally_msb:tally_lsb];
  wire correcting = !ecc_q[correction_disable_bit];
  logic init_q;
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      dyn_lock_q <= '1;
      stored_q <= stored_pattern_reset;
      training_pattern_working <= stored_pattern_reset;
      init_q <= 1'b1;
      ecc_q <= correction_status_reset;
      status_q <= status_reset;
      wel_q <= 1'b0;
      program_accepted <= 1'b0;
      sector_protected <= '0;
    end else begin
      init_q <= 1'b0;
      program_accepted <= 1'b0;
      sector_protected <= prot_d;
      // The stored pattern survives reset in a real part; model by reloading after release.
      if (init_q) training_pattern_working <= stored_q;
      if (frame_end) begin
        if (op_q == write_enable_cmd) wel_q <= 1'b1;
        else if (writes || op_q == erase_cmd) wel_q <= 1'b0;
        if (writes) begin
          case (op_q)
            write_sector_lock_cmd, write_sector_lock_wide_cmd:
              dyn_lock_q[sec] <= wdata_q != lock_protected;
            program_stored_pattern_cmd: stored_q <= wdata_q;
            write_working_pattern_cmd: training_pattern_working <= wdata_q;
            write_correction_status_cmd: ecc_q[correction_disable_bit] <= wdata_q[correction_disable_bit];
            write_status_cmd: if (!guarded) status_q <= wdata_q;
            program_cmd: program_accepted <= !target_prot && !(correcting && partial_program_attempt);
            default: ;
          endcase
        end
        if (op_q == erase_cmd && wel_q) program_accepted <= !target_prot;
        if (op_q == clear_correction_status_cmd) begin
          ecc_q[tally_msb:tally_lsb] <= '0;
          ecc_q[correction_seen_bit] <= 1'b0;
          ecc_q[partial_program_bit] <= 1'b0;
        end
      end
      // Events set after a clear in the same cycle, so the set wins.
      if (correction_event) begin
        ecc_q[correction_seen_bit] <= 1'b1;
        if (tally != tally_max) ecc_q[tally_msb:tally_lsb] <= tally + 4'd1;
      end
      if (frame_end && writes && op_q == program_cmd && correcting && partial_program_attempt)
        ecc_q[partial_program_bit] <= 1'b1;
    end
  end
endmodule

// [design/flash_protect_host.sv]
// Purpose: Host end: issues one opcode frame per software command over Avalon-MM registers.
// Assumes: Software sets the write enable frame before any write frame.
// Notes: Link clock is divided from the system clock.
`timescale 1ns/1ns
module flash_protect_host
  import flash_protect_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  flash_link_if.host link,
  input wire logic [flash_protect_pkg::addr_bits-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);
  import flash_protect_pkg::*;
  // ****************************************
  // Register decode
  // ****************************************
  logic [7:0] wd_q, rd_q;
  logic [31:0] addr_q;
  logic busy_q, sclk_q, cs_n_q, mosi_q, ack_q, rd_ack_q;
  logic [7:0] div_q;
  logic [6:0] bit_q, len_q;
  logic [47:0] sh_q;
  logic [1:0] miso_s;
  wire hit_cmd = address == reg_command;
  wire hit_addr = address == reg_address;
  wire hit_wd = address == reg_wdata;
  wire hit_rd = address == reg_rdata;
  wire start = write && hit_cmd && !busy_q && !ack_q;
  wire has_addr = writedata[7:0] == read_sector_lock_cmd || writedata[7:0] == write_sector_lock_cmd ||
                  writedata[7:0] == program_cmd || writedata[7:0] == erase_cmd;
  wire has_wide = writedata[7:0] == read_sector_lock_wide_cmd || writedata[7:0] == write_sector_lock_wide_cmd;
  wire has_dummy = writedata[7:0] == read_training_pattern_cmd;
  wire has_data = writedata[7:0] != write_enable_cmd && writedata[7:0] != clear_correction_status_cmd &&
                  writedata[7:0] != erase_cmd;
  wire [6:0] frame_len = 7'd8 + (has_wide ? 7'd32 : has_addr ? 7'd24 : 7'd0) + (has_dummy ? 7'd8 : 7'd0) +
                         (has_data ? 7'd8 : 7'd0);
  wire [31:0] status_word = {31'd0, busy_q};
  wire tick = div_q == link_half_period - 8'd1;
  wire [47:0] frame_bits = has_wide ? {writedata[7:0], addr_q, wd_q} :
                           has_addr ? {writedata[7:0], addr_q[23:0], wd_q, 8'd0} : {writedata[7:0], wd_q, 32'd0};
  wire rd_hold = hit_rd && busy_q;
  // Master holds the command write in wait until the last link clock of the frame falls.
  // Reads wait one cycle, rdata reads also until the frame ends, so that readdata, registered from the address, stands when waitrequest drops.
  assign waitrequest = (write && hit_cmd && !ack_q) || (read && (!rd_ack_q || rd_hold));
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      miso_s <= 2'b11;
      readdata <= '0;
      ack_q <= 1'b0;
      addr_q <= '0;
      wd_q <= '0;
      rd_ack_q <= 1'b0;
    end else begin
      miso_s <= {miso_s[0], link.dev_line};
      ack_q <= busy_q && tick && sclk_q && bit_q == len_q;
      if (write && hit_addr) addr_q <= writedata;
      if (write && hit_wd) wd_q <= writedata[7:0];
      rd_ack_q <= read && !rd_ack_q && !rd_hold;
      readdata <= hit_rd ? {24'd0, rd_q} : hit_cmd ? status_word : 32'd0;
    end
  end
  // ****************************************
  // Serial engine
  // ****************************************
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      div_q <= '0;
      bit_q <= '0;
      len_q <= '0;
      sh_q <= '0;
      rd_q <= '0;
    end else if (start) begin
      busy_q <= 1'b1;
      cs_n_q <= 1'b0;
      len_q <= frame_len;
      bit_q <= '0;
      div_q <= '0;
      sh_q <= {frame_bits[46:0], 1'b0};
      mosi_q <= frame_bits[47];
    end else if (busy_q) begin
      div_q <= tick ? 8'd0 : div_q + 8'd1;
      if (tick) begin
        if (!sclk_q && bit_q != len_q) begin
          sclk_q <= 1'b1;
          bit_q <= bit_q + 7'd1;
        end else if (sclk_q) begin
          // Sample at the end of the high phase: the answer crosses the device's synchroniser and ours,
          // which takes longer than half a link period.
          sclk_q <= 1'b0;
          rd_q <= {rd_q[6:0], miso_s[1]};
          mosi_q <= sh_q[47];
          sh_q <= {sh_q[46:0], 1'b0};
        end else begin
          busy_q <= 1'b0;
          cs_n_q <= 1'b1;
        end
      end
    end
  end
  assign link.link_clock = sclk_q;
  assign link.select_n = cs_n_q;
  assign link.host_data = mosi_q;
endmodule

// [verification/flash_protect_asserts.sv]
// Purpose: Concurrent checks on the serial link and the device side-band of the protection pair.
// Assumes: Link signals and device ports arrive as plain inputs; the bench holds map inputs steady.
// Notes: Device outputs may lag their causes by two system clocks.
`timescale 1ns/1ns
module flash_protect_asserts
  import flash_protect_pkg::*;
#(
  parameter int sectors = 32
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic link_clock,
  input wire logic select_n,
  input wire logic dev_data_oe_n,
  input wire logic dev_line,
  input wire logic write_protect_n,
  input wire logic [sectors-1:0] persistent_sector_lock,
  input wire logic [sectors-1:0] region_guard_map,
  input wire logic [sectors-1:0] sector_protected,
  input wire logic program_accepted,
  input wire logic [7:0] status_q,
  input wire logic [7:0] training_pattern_working
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Four clocks of idle cover the device's input synchroniser delay.
  sequence s_idle; select_n [*4]; endsequence
  sequence s_guard_held; status_q[status_write_disable_bit] && !write_protect_n; endsequence
  property p_line_idle; s_idle |-> dev_data_oe_n && dev_line; endproperty
  property p_clock_idle; s_idle |-> !link_clock; endproperty
  property p_guard_or; $stable(region_guard_map) |-> ##2 ((region_guard_map & ~sector_protected) == '0); endproperty
  property p_persist_or;
    $stable(persistent_sector_lock) |-> ##2 ((~persistent_sector_lock & ~sector_protected) == '0);
  endproperty
  property p_reset_locks;
    $rose(reset_n) |-> ##2 (sector_protected == (~persistent_sector_lock | region_guard_map));
  endproperty
  property p_reset_pattern; $rose(reset_n) |-> ##[1:2] (training_pattern_working == stored_pattern_reset); endproperty
  property p_status_guard; s_guard_held |=> $stable(status_q[7:2]); endproperty
  property p_accept_pulse; program_accepted |=> !program_accepted; endproperty
  property p_accept_idle; program_accepted |-> select_n; endproperty
  property p_pattern_frame; !$stable(training_pattern_working) |-> select_n; endproperty
  a_line_idle: assert property (p_line_idle) else $error("device drives line while idle");
  a_clock_idle: assert property (p_clock_idle) else $error("link clock moves while idle");
  a_guard_or: assert property (p_guard_or) else $error("guarded sector not protected");
  a_persist_or: assert property (p_persist_or) else $error("persistent lock ignored");
  a_reset_locks: assert property (p_reset_locks) else $error("locks not open after reset");
  a_reset_pattern: assert property (p_reset_pattern) else $error("pattern not reloaded");
  a_status_guard: assert property (p_status_guard) else $error("guarded status bits changed");
  a_accept_pulse: assert property (p_accept_pulse) else $error("accept pulse too long");
  a_accept_idle: assert property (p_accept_idle) else $error("accept inside a frame");
  a_pattern_frame: assert property (p_pattern_frame) else $error("pattern changed in frame");
endmodule

// [verification/tb_flash_protect_ecc_regs.sv]
// Purpose: Drives the host registers and checks both ends of the protection pair.
// Assumes: Host frames end a half link period after waitrequest drops; device settles within eight clocks.
// Notes: The host is the only traffic source, so it must stick to one protection scheme.
`timescale 1ns/1ns
module tb_flash_protect_ecc_regs;
  import flash_protect_pkg::*;
  localparam logic [31:0] guard = 32'h00000200;
  localparam logic [31:0] pers = 32'hFFFFFF7F;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic write_protect_n = 1'b1;
  logic correction_event = 1'b0;
  logic partial_program_attempt = 1'b0;
  logic [3:0] address = 4'h0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [31:0] readdata;
  logic waitrequest;
  logic [31:0] rd_seen;
  logic [31:0] sector_protected;
  logic program_accepted;
  logic [7:0] status_q;
  logic [7:0] training_pattern_working;
  int error_cnt = 0;
  int checks_done = 0;
  int cycles = 0;
  int acc_cnt = 0;
  int n;
  int tsec[4] = '{3, 4, 7, 9};
  flash_link_if link();
  flash_protect_host u_flash_protect_host (.clock(clock), .reset_n(reset_n), .link(link), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  flash_protect_dev u_flash_protect_dev (.clock(clock), .reset_n(reset_n), .link(link),
    .write_protect_n(write_protect_n), .correction_event(correction_event),
    .partial_program_attempt(partial_program_attempt), .persistent_sector_lock(pers), .region_guard_map(guard),
    .address_wide(1'b0), .sector_protected(sector_protected), .program_accepted(program_accepted),
    .status_q(status_q), .training_pattern_working(training_pattern_working));
  flash_protect_asserts u_asserts (.clock(clock), .reset_n(reset_n), .link_clock(link.link_clock),
    .select_n(link.select_n), .dev_data_oe_n(link.dev_data_oe_n), .dev_line(link.dev_line),
    .write_protect_n(write_protect_n), .persistent_sector_lock(pers), .region_guard_map(guard),
    .sector_protected(sector_protected), .program_accepted(program_accepted), .status_q(status_q),
    .training_pattern_working(training_pattern_working));
  // ****************************************
  // Tasks
  // ****************************************
  initial begin
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (program_accepted === 1'b1) begin
      acc_cnt <= acc_cnt + 1;
    end
    if (cycles == 80000) begin
      error_cnt = error_cnt + 1;
      stop_test();
    end
  end
  task stop_test();
    $display("checks_done %0d error_cnt %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task check(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done = checks_done + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask
  task reset_dut();
    reset_n <= 1'b0;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    do @(posedge clock); while (waitrequest !== 1'b0);
    rd_seen = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  function logic [31:0] sec(input int s);
    return 32'(s) << 12;
  endfunction
  task frame(input logic [7:0] op, input logic [31:0] a, input logic [7:0] d);
    bus(1'b1, reg_address, a);
    bus(1'b1, reg_wdata, {24'h000000, d});
    bus(1'b1, reg_command, {24'h000000, op});
    repeat (8) @(posedge clock);
  endtask
  task wframe(input logic [7:0] op, input logic [31:0] a, input logic [7:0] d);
    frame(write_enable_cmd, 32'h00000000, 8'h00);
    frame(op, a, d);
  endtask
  task rframe(input logic [7:0] op, input logic [31:0] a, input logic [7:0] e, input string nm);
    frame(op, a, 8'h00);
    bus(1'b0, reg_rdata, 32'h00000000);
    check(nm, {24'h000000, e}, {24'h000000, rd_seen[7:0]});
  endtask
  task pulse(input int k);
    repeat (k) begin
      @(posedge clock);
      correction_event <= 1'b1;
      @(posedge clock);
      correction_event <= 1'b0;
    end
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    reset_dut();
    check("pattern", 32'h00000000, {24'h000000, training_pattern_working});
    check("map", ~pers | guard, sector_protected);
    frame(write_sector_lock_cmd, sec(3), lock_protected);
    rframe(read_sector_lock_cmd, sec(3), lock_open, "lock");
    wframe(write_sector_lock_cmd, sec(3), lock_protected);
    rframe(read_sector_lock_cmd, sec(3), lock_protected, "lock");
    wframe(write_sector_lock_wide_cmd, sec(5), lock_protected);
    rframe(read_sector_lock_wide_cmd, sec(5), lock_protected, "lock wide");
    check("map", ~pers | guard | 32'h00000028, sector_protected);
    $display("test locks done");
    for (int i = 0; i < 4; i++) begin
      n = acc_cnt;
      wframe(program_cmd, sec(tsec[i]), 8'h00);
      wframe(erase_cmd, sec(tsec[i]), 8'h00);
      check("accepts", (i == 1) ? n + 2 : n, acc_cnt);
    end
    wframe(write_sector_lock_cmd, sec(3), lock_open);
    check("map", ~pers | guard | 32'h00000020, sector_protected);
    $display("test gating done");
    rframe(read_training_pattern_cmd, 32'h00000000, 8'h00, "pattern");
    wframe(write_working_pattern_cmd, 32'h00000000, 8'hA5);
    rframe(read_training_pattern_cmd, 32'h00000000, 8'hA5, "pattern");
    wframe(program_stored_pattern_cmd, 32'h00000000, 8'h3C);
    check("working", 32'h000000A5, {24'h000000, training_pattern_working});
    reset_dut();
    check("reload", {24'h000000, stored_pattern_reset}, {24'h000000, training_pattern_working});
    rframe(read_sector_lock_cmd, sec(5), lock_open, "lock");
    $display("test pattern done");
    rframe(read_correction_status_cmd, 32'h00000000, 8'h00, "ecc");
    pulse(3);
    rframe(read_correction_status_cmd, 32'h00000000, 8'h0E, "ecc");
    pulse(14);
    rframe(read_correction_status_cmd, 32'h00000000, 8'h3E, "ecc");
    wframe(write_correction_status_cmd, 32'h00000000, 8'hFF);
    rframe(read_correction_status_cmd, 32'h00000000, 8'h3F, "ecc");
    wframe(clear_correction_status_cmd, 32'h00000000, 8'h00);
    rframe(read_correction_status_cmd, 32'h00000000, 8'h01, "ecc");
    wframe(write_correction_status_cmd, 32'h00000000, 8'h00);
    partial_program_attempt <= 1'b1;
    n = acc_cnt;
    wframe(program_cmd, sec(4), 8'h00);
    partial_program_attempt <= 1'b0;
    check("accepts", n, acc_cnt);
    rframe(read_correction_status_cmd, 32'h00000000, 8'h40, "ecc");
    $display("test correction done");
    wframe(write_status_cmd, 32'h00000000, 8'hC0);
    check("status", 32'h000000C0, {24'h000000, status_q});
    write_protect_n <= 1'b0;
    wframe(write_status_cmd, 32'h00000000, 8'h00);
    check("status", 32'h000000C0, {24'h000000, status_q});
    write_protect_n <= 1'b1;
    wframe(write_status_cmd, 32'h00000000, 8'h00);
    check("status", 32'h00000000, {24'h000000, status_q});
    $display("test status done");
    stop_test();
  end
endmodule
